// [rtl/lsfs_params.svh]
`ifndef LSFS_PARAMS_SVH
`define LSFS_PARAMS_SVH

// Register byte offsets and control reset value
`define LSFS_CTRL_OFF        8'h00
`define LSFS_STAT_OFF        8'h04
`define LSFS_RXW_OFF         8'h08
`define LSFS_TXW_OFF         8'h0C
`define LSFS_CTRL_RST        1'b1

// Status field positions
`define LSFS_ST_VALID        0
`define LSFS_ST_PWR          1
`define LSFS_ST_IDLE         2
`define LSFS_ST_LOOP         3
`define LSFS_ST_AUX1         4
`define LSFS_ST_AUX2         5
`define LSFS_ST_TONE         6
`define LSFS_ST_RUN          7

// Timing
`define LSFS_HCLK_KHZ        125000
`define LSFS_OSC_KHZ         4096
`define LSFS_IDLE_US         250
`define LSFS_FREE_US         125
`define LSFS_US_TICKS(us)    (((us) * `LSFS_OSC_KHZ) / 1000)
`define LSFS_CCLK_DIV        32
`define LSFS_CCLK_PERIODS    16
`define LSFS_WIN_PERIODS     8
`define LSFS_BIT_KHZ         256
`define LSFS_MOD_DLY_BITS    4
`define LSFS_MOD_DLY_TICKS   ((`LSFS_OSC_KHZ / `LSFS_BIT_KHZ) * `LSFS_MOD_DLY_BITS)
`define LSFS_TONE_HZ         500
`define LSFS_TONE_HALF_TICKS ((`LSFS_OSC_KHZ * 1000) / (2 * `LSFS_TONE_HZ))

// Tone codes, positive and negative half
`define LSFS_MU_HI           8'h9E
`define LSFS_MU_LO           8'h1E
`define LSFS_A_HI            8'hB4
`define LSFS_A_LO            8'h34

`endif

// [rtl/lsfs_pkg.sv]
package lsfs_pkg;

	typedef enum logic [2:0] {
		LSFS_IDLE = 3'b001,
		LSFS_RUN  = 3'b010,
		LSFS_HOLD = 3'b100
	} lsfs_frame_t;

	typedef struct packed {
		logic [16:0] acc;
		logic        osc_tick;
		logic [10:0] idle_cnt;
		logic        idle;
		logic [9:0]  free_cnt;
		logic        free_tick;
	} lsfs_tmr_t;

	typedef struct packed {
		logic [6:0]  sy1;
		logic [6:0]  sy2;
		lsfs_frame_t st;
		logic [9:0]  phase;
		logic        win;
		logic        cclk;
		logic        vout;
		logic [7:0]  txw;
		logic [7:0]  rxw;
		logic [7:0]  demw;
		logic [7:0]  mvoice;
		logic [1:0]  maux;
		logic        mstart;
		logic        pend;
		logic [1:0]  auxo;
		logic        valid;
		logic        pd_o;
		logic        free_par;
		logic [12:0] tone_cnt;
		logic        tone_ph;
		logic        enable;
		logic        wr;
		logic [7:0]  waddr;
		logic [31:0] hrdata;
	} lsfs_seq_t;

endpackage : lsfs_pkg

// [rtl/lsfs_tick_if.sv]
`timescale 1ns/100ps
interface lsfs_tick_if;
	logic osc_tick;
	logic idle;
	logic free_tick;
	logic demod_seen;
	modport src (output osc_tick, output idle, output free_tick, input demod_seen);
	modport snk (input osc_tick, input idle, input free_tick, output demod_seen);
endinterface : lsfs_tick_if

// [rtl/lsfs_osc_timer.sv]
`timescale 1ns/100ps
`include "lsfs_params.svh"
module lsfs_osc_timer
	import lsfs_pkg::*;
#(
	parameter int HCLK_KHZ = `LSFS_HCLK_KHZ,
	parameter int OSC_KHZ  = `LSFS_OSC_KHZ
) (
	input  wire logic  hclk,
	input  wire logic  hresetn,
	lsfs_tick_if.src   tk
);
	localparam logic [17:0] HCLK_W = 18'(HCLK_KHZ);
	localparam logic [17:0] OSC_W  = 18'(OSC_KHZ);
	localparam logic [10:0] IDLE_T = 11'(`LSFS_US_TICKS(`LSFS_IDLE_US));
	localparam logic [9:0]  FREE_T = 10'(`LSFS_US_TICKS(`LSFS_FREE_US));

	lsfs_tmr_t q;
	lsfs_tmr_t d;
	logic [17:0] sum;

	always_comb begin
		d = q;
		d.osc_tick = 1'b0;
		d.free_tick = 1'b0;
		// Fractional divider: 4.096 MHz tick from the bus clock
		sum = {1'b0, q.acc} + OSC_W;
		if (sum >= HCLK_W) begin
			sum = sum - HCLK_W;
			d.osc_tick = 1'b1;
		end
		d.acc = sum[16:0];
		if (tk.demod_seen) begin
			d.idle_cnt = 11'h000;
			d.idle = 1'b0;
			d.free_cnt = 10'h000;
		end else if (q.osc_tick) begin
			if (!q.idle) begin
				if (q.idle_cnt == IDLE_T - 11'h001) begin
					d.idle = 1'b1; // RL9
				end else begin
					d.idle_cnt = q.idle_cnt + 11'h001;
				end
			end else if (q.free_cnt == FREE_T - 10'h001) begin
				d.free_cnt = 10'h000;
				d.free_tick = 1'b1; // RL17
			end else begin
				d.free_cnt = q.free_cnt + 10'h001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '{acc: 17'h00000, osc_tick: 1'b0, idle_cnt: 11'h000, idle: 1'b1,
			       free_cnt: 10'h000, free_tick: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign tk.osc_tick  = q.osc_tick;
	assign tk.idle      = q.idle;
	assign tk.free_tick = q.free_tick;
endmodule : lsfs_osc_timer

// [rtl/lsfs_frame_seq.sv]
// Notes on behaviour
// (RL1) Transmit window high eight codec periods
// (RL2) Voice bits out on rising edges, else float
// (RL3) Aux outputs and valid flag at window rise
// (RL4) Receive window is inverse of transmit window
// (RL5) Codec word sampled on eight falling edges
// (RL6) Codec clock 128 kHz, sixteen periods per frame
// (RL7) Divide oscillator by 32, stretch last low
// (RL8) Valid only with good sync, no errors
// (RL9) Valid low after 250 us without bursts
// (RL10) Aux inputs latched at window or tick
// (RL11) Controller keeps aux inputs stable until valid
// (RL12) Loopback returns demodulated word when powered
// (RL13) Codec clock held low during loopback
// (RL14) Power-down stops transmitting, rest keeps running
// (RL15) Powered up: answer each master burst
// (RL16) Return burst starts four bit periods later
// (RL17) Free 125 us tick, burst every second
// (RL18) Weak power line drive high/low by activity
// (RL19) Tone request replaces voice with square wave
// (RL20) Tone request makes frames without bursts
// (RL21) Law select: one mu-law, zero A-law
// (RL22) Tone codes from companding tables
// (RL23) Demodulator gives strobe, word, bits, status
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/100ps
`include "lsfs_params.svh"
module lsfs_frame_seq
	import lsfs_pkg::*;
#(
	parameter int HCLK_KHZ = `LSFS_HCLK_KHZ
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        demod_done,
	input  wire logic [7:0]  demod_voice,
	input  wire logic [1:0]  demod_aux,
	input  wire logic        demod_ok,
	output logic             mod_start,
	output logic [7:0]       mod_voice,
	output logic [1:0]       mod_aux,
	output logic             transmit_window,
	output logic             receive_window,
	output logic             codec_clk,
	output logic             voice_out,
	output logic             voice_out_oe,
	input  wire logic        voice_in,
	input  wire logic        aux_bit_in_1,
	input  wire logic        aux_bit_in_2,
	output logic             aux_bit_out_1,
	output logic             aux_bit_out_2,
	output logic             valid_frame_flag,
	input  wire logic        loop_test_n,
	input  wire logic        tone_request,
	input  wire logic        tone_law_select,
	input  wire logic        power_down_line_i,
	output logic             power_down_line_o,
	output logic             power_down_line_oe
);
	localparam logic [9:0]  WIN_PH   = 10'(`LSFS_CCLK_DIV * `LSFS_WIN_PERIODS);
	localparam logic [9:0]  FRAME_PH = 10'(`LSFS_CCLK_DIV * `LSFS_CCLK_PERIODS);
	localparam logic [9:0]  MOD_PH   = 10'(`LSFS_MOD_DLY_TICKS);
	localparam logic [4:0]  FALL_PH  = 5'(`LSFS_CCLK_DIV / 2);
	localparam logic [12:0] TONE_T   = 13'(`LSFS_TONE_HALF_TICKS);

	// Synchroniser bit positions
	localparam int S_VIN  = 0;
	localparam int S_AUX1 = 1;
	localparam int S_AUX2 = 2;
	localparam int S_LOOP = 3;
	localparam int S_TONE = 4;
	localparam int S_LAW  = 5;
	localparam int S_PWR  = 6;

	lsfs_seq_t   q;
	lsfs_seq_t   d;
	logic        pwr;
	logic        loop;
	logic        tone;
	logic        start_dem;
	logic        start_tone;
	logic [7:0]  tcode;
	logic [7:0]  word;
	logic [31:0] rd;

	lsfs_tick_if tk ();

	lsfs_osc_timer #(
		.HCLK_KHZ (HCLK_KHZ),
		.OSC_KHZ  (`LSFS_OSC_KHZ)
	) u_tmr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tk      (tk)
	);

	// RL23
	assign tk.demod_seen = demod_done;

	always_comb begin
		d = q;
		d.sy1 = {power_down_line_i, tone_law_select, tone_request, loop_test_n,
		         aux_bit_in_2, aux_bit_in_1, voice_in};
		d.sy2 = q.sy1;
		d.mstart = 1'b0;
		pwr = q.sy2[S_PWR];
		loop = ~q.sy2[S_LOOP] & pwr; // RL12
		tone = q.sy2[S_TONE];

		// Square wave phase, flips every half period of the tone
		if (!tone) begin
			d.tone_cnt = 13'h0000;
			d.tone_ph = 1'b0;
		end else if (tk.osc_tick) begin
			if (q.tone_cnt == TONE_T - 13'h0001) begin
				d.tone_cnt = 13'h0000;
				d.tone_ph = ~q.tone_ph;
			end else begin
				d.tone_cnt = q.tone_cnt + 13'h0001;
			end
		end
		if (q.sy2[S_LAW]) begin
			tcode = q.tone_ph ? `LSFS_MU_HI : `LSFS_MU_LO; // RL21 RL22
		end else begin
			tcode = q.tone_ph ? `LSFS_A_HI : `LSFS_A_LO; // RL21 RL22
		end
		word = tone ? tcode : demod_voice; // RL19

		start_dem = demod_done & q.enable;
		start_tone = tk.free_tick & tone & ~start_dem; // RL20

		// Running frame, one phase step per oscillator tick
		if (q.st == LSFS_RUN && tk.osc_tick) begin
			d.phase = q.phase + 10'h001;
			if (d.phase[4:0] == 5'h00 && d.phase < WIN_PH) begin
				d.vout = q.txw[6]; // RL2
				d.txw = {q.txw[6:0], 1'b0};
			end
			if (d.phase == WIN_PH) begin
				d.win = 1'b0; // RL1
			end
			if (d.phase[4:0] == FALL_PH && d.phase > WIN_PH && !loop) begin
				d.rxw = {q.rxw[6:0], q.sy2[S_VIN]}; // RL5
			end
			if (d.phase == MOD_PH && q.pend) begin
				d.mstart = 1'b1; // RL16
				d.pend = 1'b0;
			end
			if (d.phase == FRAME_PH) begin
				d.st = LSFS_HOLD; // RL7
			end
		end

		if (start_dem || start_tone) begin
			d.st = LSFS_RUN; // RL6
			d.phase = 10'h000;
			d.win = 1'b1; // RL1
			d.txw = word;
			d.vout = word[7]; // RL2
		end

		if (start_dem) begin
			d.auxo = demod_aux; // RL3
			d.valid = demod_ok; // RL3 RL8
			d.demw = demod_voice;
			d.maux = {q.sy2[S_AUX2], q.sy2[S_AUX1]}; // RL10
			d.mvoice = loop ? demod_voice : q.rxw; // RL12
			d.pend = pwr; // RL14 RL15
			d.pd_o = 1'b1; // RL18
			d.free_par = 1'b0;
		end else begin
			if (tk.idle) begin
				d.valid = 1'b0; // RL9
				d.pd_o = 1'b0; // RL18
			end
			if (tk.free_tick) begin
				d.free_par = ~q.free_par;
				if (pwr && q.free_par) begin
					d.mstart = 1'b1; // RL17
					d.mvoice = q.rxw;
					d.maux = {q.sy2[S_AUX2], q.sy2[S_AUX1]}; // RL10
				end
			end
		end

		// Clock high in the first half of each period, low in loopback
		d.cclk = (d.st == LSFS_RUN) & ~d.phase[4] & ~loop; // RL6 RL7 RL13

		// Bus data phase: write control
		if (q.wr && q.waddr == `LSFS_CTRL_OFF) begin
			d.enable = hwdata[0];
		end

		rd = 32'h0000_0000;
		case (haddr[7:0])
			`LSFS_CTRL_OFF: begin
				rd[0] = (q.wr && q.waddr == `LSFS_CTRL_OFF) ? hwdata[0] : q.enable;
			end
			`LSFS_STAT_OFF: begin
				rd[`LSFS_ST_VALID] = q.valid;
				rd[`LSFS_ST_PWR] = pwr;
				rd[`LSFS_ST_IDLE] = tk.idle;
				rd[`LSFS_ST_LOOP] = loop;
				rd[`LSFS_ST_AUX1] = q.auxo[0];
				rd[`LSFS_ST_AUX2] = q.auxo[1];
				rd[`LSFS_ST_TONE] = tone;
				rd[`LSFS_ST_RUN] = (q.st == LSFS_RUN);
			end
			`LSFS_RXW_OFF: begin
				rd[7:0] = q.demw;
			end
			`LSFS_TXW_OFF: begin
				rd[7:0] = q.rxw;
			end
			default: begin
				rd = 32'h0000_0000;
			end
		endcase

		// Bus address phase
		d.wr = 1'b0;
		if (hsel && hready && htrans[1]) begin
			d.wr = hwrite;
			d.waddr = haddr[7:0];
			d.hrdata = hwrite ? 32'h0000_0000 : rd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '{
				sy1:      7'h00,
				sy2:      7'h00,
				st:       LSFS_IDLE,
				phase:    10'h000,
				win:      1'b0,
				cclk:     1'b0,
				vout:     1'b0,
				txw:      8'h00,
				rxw:      8'h00,
				demw:     8'h00,
				mvoice:   8'h00,
				maux:     2'h0,
				mstart:   1'b0,
				pend:     1'b0,
				auxo:     2'h0,
				valid:    1'b0,
				pd_o:     1'b0,
				free_par: 1'b0,
				tone_cnt: 13'h0000,
				tone_ph:  1'b0,
				enable:   `LSFS_CTRL_RST,
				wr:       1'b0,
				waddr:    8'h00,
				hrdata:   32'h0000_0000
			};
		end else begin
			q <= d;
		end
	end

	assign hreadyout          = 1'b1;
	assign hresp              = 1'b0;
	assign hrdata             = q.hrdata;
	assign mod_start          = q.mstart;
	assign mod_voice          = q.mvoice;
	assign mod_aux            = q.maux;
	assign transmit_window    = q.win;
	assign receive_window     = ~q.win; // RL4
	assign codec_clk          = q.cclk;
	assign voice_out          = q.vout;
	assign voice_out_oe       = q.win; // RL2
	assign aux_bit_out_1      = q.auxo[0];
	assign aux_bit_out_2      = q.auxo[1];
	assign valid_frame_flag   = q.valid;
	assign power_down_line_o  = q.pd_o;
	assign power_down_line_oe = 1'b1; // RL18
endmodule : lsfs_frame_seq

// [testbench/lsfs_props.sv]
`timescale 1ns/100ps
module lsfs_props
	import lsfs_pkg::*;
#(
	parameter int HCLK_KHZ = 125000
) (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       demod_done,
	input wire logic [1:0] demod_aux,
	input wire logic       demod_ok,
	input wire logic       mod_start,
	input wire logic       transmit_window,
	input wire logic       receive_window,
	input wire logic       codec_clk,
	input wire logic       voice_out_oe,
	input wire logic       aux_bit_out_1,
	input wire logic       aux_bit_out_2,
	input wire logic       valid_frame_flag,
	input wire logic       loop_test_n,
	input wire logic       power_down_line_i,
	input wire logic       power_down_line_o
);
	localparam int TK = HCLK_KHZ / 4096;
	logic [15:0] fc_q;
	logic [15:0] wc_q;
	logic [15:0] hc_q;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Cycles since last strobe, window high time, clock high time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fc_q <= 16'hFFFF;
			wc_q <= 16'h0000;
			hc_q <= 16'h0000;
		end else begin
			fc_q <= demod_done ? 16'h0000 : fc_q + {15'h0000, fc_q != 16'hFFFF};
			wc_q <= transmit_window ? wc_q + 16'h0001 : 16'h0000;
			hc_q <= codec_clk ? hc_q + 16'h0001 : 16'h0000;
		end
	end
	sequence s_start;
		demod_done ##1 $rose(transmit_window);
	endsequence
	property p_inv; receive_window == !transmit_window; endproperty
	property p_oe; voice_out_oe == transmit_window; endproperty
	property p_win; $fell(transmit_window) |-> wc_q >= 255 * TK && wc_q <= 257 * TK; endproperty
	property p_clk; $fell(codec_clk) |-> hc_q >= 15 * TK && hc_q <= 17 * TK; endproperty
	property p_loop; (!loop_test_n && power_down_line_i) [*4] |-> !codec_clk; endproperty
	property p_vld; s_start |-> valid_frame_flag == $past(demod_ok); endproperty
	property p_aux; s_start |-> {aux_bit_out_2, aux_bit_out_1} == $past(demod_aux); endproperty
	property p_chg; !$stable({aux_bit_out_2, aux_bit_out_1}) || $rose(valid_frame_flag) |-> $rose(transmit_window);
	endproperty
	property p_mod; mod_start && fc_q < 512 * TK |-> fc_q >= 63 * TK && fc_q <= 65 * TK + 2; endproperty
	property p_idle; fc_q > 1024 * TK + 8 |-> !valid_frame_flag && !power_down_line_o; endproperty
	property p_pdhi; s_start |-> power_down_line_o; endproperty
	a_inv: assert property (p_inv) else $error("receive window not inverse");
	a_oe: assert property (p_oe) else $error("voice output enable off window");
	a_win: assert property (p_win) else $error("window length wrong");
	a_clk: assert property (p_clk) else $error("codec clock high time wrong");
	a_loop: assert property (p_loop) else $error("codec clock runs in loopback");
	a_vld: assert property (p_vld) else $error("valid flag wrong at window rise");
	a_aux: assert property (p_aux) else $error("aux outputs wrong at window rise");
	a_chg: assert property (p_chg) else $error("aux or valid changed off window rise");
	a_mod: assert property (p_mod) else $error("return burst start delay wrong");
	a_idle: assert property (p_idle) else $error("valid or power drive high while idle");
	a_pdhi: assert property (p_pdhi) else $error("power drive not high after burst");
endmodule : lsfs_props

bind lsfs_frame_seq lsfs_props #(.HCLK_KHZ(HCLK_KHZ)) u_props (
	.hclk(hclk), .hresetn(hresetn), .demod_done(demod_done), .demod_aux(demod_aux), .demod_ok(demod_ok),
	.mod_start(mod_start), .transmit_window(transmit_window), .receive_window(receive_window),
	.codec_clk(codec_clk), .voice_out_oe(voice_out_oe), .aux_bit_out_1(aux_bit_out_1),
	.aux_bit_out_2(aux_bit_out_2), .valid_frame_flag(valid_frame_flag), .loop_test_n(loop_test_n),
	.power_down_line_i(power_down_line_i), .power_down_line_o(power_down_line_o));

// [testbench/lsfs_codec_model.sv]
`timescale 1ns/100ps
module lsfs_codec_model
	import lsfs_pkg::*;
(
	input wire logic       hclk,
	input wire logic       codec_clk,
	input wire logic       transmit_window,
	input wire logic       receive_window,
	input wire logic       voice_out,
	input wire logic [7:0] word,
	output logic           voice_in,
	output logic [7:0]     heard,
	output logic [4:0]     nrise
);
	logic       cq  = 1'b0;
	logic       tq  = 1'b0;
	logic       rel = 1'b1;
	logic [3:0] k   = 4'h0;
	initial begin
		voice_in = 1'b0;
		heard = 8'h00;
		nrise = 5'h00;
	end
	always @(posedge hclk) begin
		cq <= codec_clk;
		tq <= transmit_window;
		if (codec_clk && !cq) begin
			nrise <= (transmit_window && !tq) ? 5'h01 : nrise + 5'h01;
			if (transmit_window) heard <= {heard[6:0], voice_out};
		end
		// Word goes out MSB first; the line toggles while it carries no bit
		if (transmit_window) begin
			k <= 4'h0;
			rel <= 1'b1;
			voice_in <= ~voice_in;
		end else if (codec_clk && !cq && k < 4'h8) begin
			voice_in <= word[3'h7 - k[2:0]];
			k <= k + 4'h1;
			rel <= 1'b0;
		end else if (!codec_clk && cq && k == 4'h8) rel <= 1'b1;
		else if (rel) voice_in <= ~voice_in;
	end
endmodule : lsfs_codec_model

// [testbench/loop_slave_frame_sequencer_bench.sv]
`timescale 1ns/100ps
`include "lsfs_params.svh"
module loop_slave_frame_sequencer_bench
	import lsfs_pkg::*;
;
	typedef struct packed {
		logic [7:0] v;
		logic [1:0] a;
		logic       ok;
		logic [7:0] cw;
		logic [1:0] ain;
	} lsfs_row_t;
	lsfs_row_t   rows [3] = '{'{8'hA5, 2'h1, 1'b1, 8'hC3, 2'h2}, '{8'h3C, 2'h2, 1'b0, 8'h0F, 2'h1},
		'{8'h81, 2'h3, 1'b1, 8'h7E, 2'h3}};
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, demod_done = 1'b0, demod_ok = 1'b0;
	logic        aux_bit_in_1 = 1'b0, aux_bit_in_2 = 1'b0, loop_test_n = 1'b1, ext_val = 1'b1;
	logic        tone_request = 1'b0, tone_law_select = 1'b1, seen;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, hrdata;
	logic [1:0]  htrans = 2'h0, demod_aux = 2'h0, mod_aux;
	logic [7:0]  demod_voice = 8'h00, cw = 8'h00, heard, pw, mod_voice;
	logic [4:0]  nrise;
	logic        hreadyout, hresp, mod_start, transmit_window, receive_window, codec_clk, voice_out, voice_out_oe;
	logic        voice_in, aux_bit_out_1, aux_bit_out_2, valid_frame_flag, power_down_line_o, power_down_line_oe;
	int          bad_count = 0, samples_checked = 0, cyc = 0, t;
	// Fast tick: two cycles per oscillator tick
	lsfs_frame_seq #(.HCLK_KHZ(8192)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .demod_done(demod_done), .demod_voice(demod_voice), .demod_aux(demod_aux),
		.demod_ok(demod_ok), .mod_start(mod_start), .mod_voice(mod_voice), .mod_aux(mod_aux),
		.transmit_window(transmit_window), .receive_window(receive_window), .codec_clk(codec_clk),
		.voice_out(voice_out), .voice_out_oe(voice_out_oe), .voice_in(voice_in),
		.aux_bit_in_1(aux_bit_in_1), .aux_bit_in_2(aux_bit_in_2), .aux_bit_out_1(aux_bit_out_1),
		.aux_bit_out_2(aux_bit_out_2), .valid_frame_flag(valid_frame_flag), .loop_test_n(loop_test_n),
		.tone_request(tone_request), .tone_law_select(tone_law_select), .power_down_line_i(ext_val),
		.power_down_line_o(power_down_line_o), .power_down_line_oe(power_down_line_oe));
	lsfs_codec_model u_codec (
		.hclk(hclk), .codec_clk(codec_clk), .transmit_window(transmit_window),
		.receive_window(receive_window), .voice_out(voice_out), .word(cw), .voice_in(voice_in),
		.heard(heard), .nrise(nrise));
	always #4 hclk = ~hclk;
	task close_out;
		$display("checks %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			close_out();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk(hresp, 32'h0);
	endtask : ahb
	task send(input logic [7:0] v, input logic [1:0] a, input logic ok);
		repeat (4) @(posedge hclk);
		demod_voice <= v;
		demod_aux <= a;
		demod_ok <= ok;
		demod_done <= 1'b1;
		@(posedge hclk);
		demod_done <= 1'b0;
	endtask : send
	task wsig(input logic m, input int lim);
		seen = 1'b0;
		for (t = 0; t < lim && seen !== 1'b1; t++) begin
			@(posedge hclk);
			seen = m ? mod_start : transmit_window;
		end
	endtask : wsig
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		chk(receive_window, 1'b1);
		ahb(1'b0, 32'h0, 32'h0);
		chk(r, 32'h1);
		for (int i = 0; i < 3; i++) begin
			cw <= rows[i].cw;
			{aux_bit_in_2, aux_bit_in_1} <= rows[i].ain;
			send(rows[i].v, rows[i].a, rows[i].ok);
			wsig(1'b0, 8);
			chk(seen, 1'b1);
			chk({aux_bit_out_2, aux_bit_out_1}, rows[i].a);
			chk(valid_frame_flag, rows[i].ok);
			chk(power_down_line_o, 1'b1);
			wsig(1'b1, 200);
			chk(seen, 1'b1);
			chk(mod_aux, rows[i].ain);
			if (i > 0) chk(mod_voice, pw);
			repeat (1000) @(posedge hclk);
			chk(heard, rows[i].v);
			chk(nrise, 5'h10);
			ahb(1'b0, 32'hC, 32'h0);
			chk(r, rows[i].cw);
			ahb(1'b0, 32'h4, 32'h0);
			chk(r[5:0], {rows[i].a, 3'h1, rows[i].ok});
			pw = rows[i].cw;
		end
		// Strobes ignored while disabled; unmapped word reads zero
		ahb(1'b1, 32'h0, 32'h0);
		send(8'h11, 2'h0, 1'b1);
		wsig(1'b0, 20);
		chk(seen, 1'b0);
		ahb(1'b1, 32'h0, 32'h1);
		ahb(1'b0, 32'h10, 32'h0);
		chk(r, 32'h0);
		loop_test_n <= 1'b0;
		send(8'h5A, 2'h1, 1'b1);
		wsig(1'b1, 200);
		chk(mod_voice, 8'h5A);
		chk(mod_aux, rows[2].ain);
		ahb(1'b0, 32'h4, 32'h0);
		chk(r[3], 1'b1);
		repeat (1000) @(posedge hclk);
		loop_test_n <= 1'b1;
		ext_val <= 1'b0;
		send(8'h66, 2'h2, 1'b1);
		wsig(1'b0, 8);
		chk({aux_bit_out_2, aux_bit_out_1}, 2'h2);
		wsig(1'b1, 300);
		chk(seen, 1'b0);
		ext_val <= 1'b1;
		wsig(1'b1, 5000);
		chk(seen, 1'b1);
		wsig(1'b1, 2100);
		chk(t >= 2046 && t <= 2050, 1'b1);
		chk(valid_frame_flag, 1'b0);
		chk(power_down_line_o, 1'b0);
		chk(power_down_line_oe, 1'b1);
		ahb(1'b0, 32'h4, 32'h0);
		chk(r[2], 1'b1);
		for (int l = 0; l < 2; l++) begin
			tone_law_select <= (l == 0);
			tone_request <= 1'b1;
			wsig(1'b0, 1100);
			chk(seen, 1'b1);
			repeat (600) @(posedge hclk);
			chk(heard === (l ? `LSFS_A_HI : `LSFS_MU_HI) || heard === (l ? `LSFS_A_LO : `LSFS_MU_LO), 1'b1);
		end
		tone_request <= 1'b0;
		// Reset in mid-frame with control cleared: outputs and enable return to idle values
		send(8'h24, 2'h3, 1'b1);
		wsig(1'b0, 8);
		chk(power_down_line_o, 1'b1);
		ahb(1'b1, 32'h0, 32'h0);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(transmit_window, 1'b0);
		chk(receive_window, 1'b1);
		chk({valid_frame_flag, aux_bit_out_2, aux_bit_out_1}, 3'h0);
		hresetn <= 1'b1;
		ahb(1'b0, 32'h0, 32'h0);
		chk(r, 32'h1);
		close_out();
	end
endmodule : loop_slave_frame_sequencer_bench
